// ==== tsm_pkg.sv ====
package tsm_pkg;

  // Device clock and the bus-stuck limit; the limit rounds down to whole cycles.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_MS    = 30;
  localparam int TIMEOUT_CYC   = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CONV_CYC      = 2000;

  // Two-wire slave address and the high-speed master code pattern.
  localparam logic [6:0] DEV_ADDR_DEF = 7'h4c;
  localparam logic [7:0] HS_MASK      = 8'hf8;
  localparam logic [7:0] HS_CODE      = 8'h08;

  // Pointer values seen on the two-wire bus.
  localparam logic [7:0] PTR_LOCAL  = 8'h00;
  localparam logic [7:0] PTR_REMOTE = 8'h01;
  localparam logic [7:0] PTR_CFG1   = 8'h09;

  // Word offsets on the plain register port.
  localparam logic [3:0] ADR_CFG    = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h1;
  localparam logic [3:0] ADR_LOCAL  = 4'h2;
  localparam logic [3:0] ADR_REMOTE = 4'h3;
  localparam logic [3:0] ADR_PTR    = 4'h4;
  localparam logic [3:0] ADR_SEL    = 4'h5;

  // Field positions and reset values.
  localparam int         CFG_SD_BIT = 6;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] PTR_RST    = 8'h00;
  localparam int         OPEN_BIT   = 0;
  localparam int         SUPPLY_INVALID_FLAG_BIT   = 1;
  localparam logic [7:0] SHORT_TEMP = 8'hc0;

  // Bit counter positions within a nine-clock byte slot.
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;

  typedef enum logic [6:0] {
    LK_IDLE  = 7'h01,
    LK_ADDR  = 7'h02,
    LK_HS    = 7'h04,
    LK_PTR   = 7'h08,
    LK_WDATA = 7'h10,
    LK_RDATA = 7'h20,
    LK_IGN   = 7'h40
  } link_st_e;

  typedef enum logic [2:0] {
    CV_OFF  = 3'h1,
    CV_RUN  = 3'h2,
    CV_SKIP = 3'h4
  } conv_st_e;

endpackage : tsm_pkg

// ==== tsm_ifs.sv ====
`timescale 1ns/100ps
`default_nettype none

// Bit captured on the link clock, read by the engine after a clock rise.
interface link_if;
  logic bit_val;
  modport smp (output bit_val);
  modport eng (input bit_val);
endinterface : link_if

// Conversion control and results between engine and sequencer.
interface conv_if;
  logic        sd_req;
  logic [15:0] local_res;
  logic [15:0] remote_res;
  logic        converting;
  logic        powered_down;
  modport ctl (input sd_req, output local_res, output remote_res, output converting, output powered_down);
  modport usr (output sd_req, input local_res, input remote_res, input converting, input powered_down);
endinterface : conv_if

`default_nettype wire

// ==== link_sampler.sv ====
`timescale 1ns/100ps
`default_nettype none

module link_sampler (
  input  wire logic scl_clk,
  input  wire logic sda_in,
  link_if.smp       lk
);

  // Data is captured on the link's own clock and then held for a full clock period,
  // so the device side may read it once it has seen the rise through its synchroniser.
  always_ff @(posedge scl_clk) begin
    lk.bit_val <= sda_in;
  end

endmodule : link_sampler

`default_nettype wire

// ==== conv_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

module conv_ctrl #(
  parameter int unsigned CONV_CYCLES = tsm_pkg::CONV_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  conv_if.ctl              cv,
  input  wire logic        open_cmp,
  input  wire logic        short_cmp,
  input  wire logic        supply_cmp,
  input  wire logic [11:0] adc_local,
  input  wire logic [11:0] adc_remote,
  output logic             analog_pd,
  output logic             adc_busy
);

  localparam int CW = $clog2(CONV_CYCLES + 1);

  tsm_pkg::conv_st_e st_q;
  logic [2:0]        s1_q;
  logic [2:0]        s2_q;
  logic [CW-1:0]     cnt_q;
  logic              fault_q;
  logic              open_s;
  logic              short_s;
  logic              supply_s;
  logic              done;
  logic              fault_now;

  // Comparators switch at any time, so each passes two flops first.
  always_ff @(posedge mclk) begin
    s1_q <= {supply_cmp, short_cmp, open_cmp};                    // [R17]
    s2_q <= s1_q;
  end
  assign open_s    = s2_q[0];
  assign short_s   = s2_q[1];
  assign supply_s  = s2_q[2];
  assign done      = (st_q != tsm_pkg::CV_OFF) && (cnt_q == CW'(CONV_CYCLES - 1));
  assign fault_now = fault_q || open_s;

  // A shutdown request is honoured only at a period boundary, never mid-conversion.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= tsm_pkg::CV_OFF;
    end else begin
      case (st_q)
        tsm_pkg::CV_OFF: begin
          if (!cv.sd_req) begin
            st_q <= supply_s ? tsm_pkg::CV_RUN : tsm_pkg::CV_SKIP;   // [R11] [R15]
          end
        end
        tsm_pkg::CV_RUN, tsm_pkg::CV_SKIP: begin
          if (done && cv.sd_req) begin
            st_q <= tsm_pkg::CV_OFF;                                 // [R9] [R10]
          end else if (done) begin
            st_q <= supply_s ? tsm_pkg::CV_RUN : tsm_pkg::CV_SKIP;   // [R11] [R15]
          end
        end
        default: st_q <= tsm_pkg::CV_OFF;
      endcase
    end
  end

  // Period counter; it rests while powered down.
  always_ff @(posedge mclk) begin
    if (!rst_n || st_q == tsm_pkg::CV_OFF || done) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // The open-diode comparator is watched over the whole conversion.
  always_ff @(posedge mclk) begin
    if (!rst_n || st_q != tsm_pkg::CV_RUN || done) begin
      fault_q <= 1'b0;
    end else if (open_s) begin
      fault_q <= 1'b1;                                             // [R12]
    end
  end

  // Results: open flag and short value on the remote channel, supply-invalid flag on both channels.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cv.local_res  <= 16'h0000;
      cv.remote_res <= 16'h0000;
    end else if (st_q == tsm_pkg::CV_SKIP) begin
      cv.local_res[tsm_pkg::SUPPLY_INVALID_FLAG_BIT]  <= 1'b1;                    // [R16]
      cv.remote_res[tsm_pkg::SUPPLY_INVALID_FLAG_BIT] <= 1'b1;                    // [R16]
    end else if (done) begin
      cv.local_res <= {adc_local, 2'b00, !supply_s, 1'b0};
      if (short_s && !fault_now) begin
        cv.remote_res <= {tsm_pkg::SHORT_TEMP, 4'h0, 2'b00, !supply_s, 1'b0};  // [R14]
      end else begin
        cv.remote_res <= {adc_remote, 2'b00, !supply_s, fault_now};            // [R12]
      end
    end
  end

  // Status and analog controls, all registered.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      analog_pd       <= 1'b1;
      adc_busy        <= 1'b0;
      cv.converting   <= 1'b0;
      cv.powered_down <= 1'b1;
    end else begin
      analog_pd       <= (st_q == tsm_pkg::CV_OFF);               // [R9]
      adc_busy        <= (st_q == tsm_pkg::CV_RUN);               // [R15]
      cv.converting   <= (st_q == tsm_pkg::CV_RUN);
      cv.powered_down <= (st_q == tsm_pkg::CV_OFF);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_sd_off: assert property (done && cv.sd_req |=> st_q == tsm_pkg::CV_OFF ##1 analog_pd)  // [R9]
    else $error("shutdown not entered at period end");
  a_sd_wait: assert property (st_q == tsm_pkg::CV_RUN && !done |=> st_q == tsm_pkg::CV_RUN)  // [R10]
    else $error("conversion cut short");
  a_run_on: assert property (done && !cv.sd_req |=> st_q != tsm_pkg::CV_OFF && cnt_q == '0)  // [R11]
    else $error("continuous conversion stopped");
  a_open_flag: assert property (done && st_q == tsm_pkg::CV_RUN && fault_now |=> cv.remote_res[0])  // [R12]
    else $error("open fault not flagged");
  a_short_val: assert property (done && st_q == tsm_pkg::CV_RUN && short_s && !fault_now
                                |=> cv.remote_res[15:8] == tsm_pkg::SHORT_TEMP)  // [R14]
    else $error("short value wrong");
  a_skip_conv: assert property (done && !supply_s && !cv.sd_req |=> st_q == tsm_pkg::CV_SKIP ##1 !adc_busy)  // [R15]
    else $error("conversion with bad supply");
  a_supply_invalid_flag_flag: assert property (st_q == tsm_pkg::CV_SKIP |=> cv.local_res[1] && cv.remote_res[1])  // [R16]
    else $error("supply flag missing");
  a_cmp_sync: assert property (supply_s == $past(supply_cmp, 2) && open_s == $past(open_cmp, 2))  // [R17]
    else $error("comparator sync depth wrong");

  c_shutdown: cover property (done && cv.sd_req);
  c_skip: cover property (st_q == tsm_pkg::CV_SKIP);

endmodule : conv_ctrl

`default_nettype wire

// ==== temp_sensor_bus_status_ctrl.sv ====
// How it works
// [R1] A first byte 0000_1xxx after START is the high-speed code and is not acknowledged.
// [R2] That code switches the line filters to high-speed mode.
// [R3] The master sends the high-speed code before clocking faster than fast mode.
// [R4] After the code the master restarts and sends a slave address byte.
// [R5] High-speed filter mode holds until a STOP, then fast mode returns.
// [R6] A line held low too long inside a transaction resets the interface.
// [R7] On that timeout the device releases data and waits for a fresh START.
// [R8] The master keeps the clock above the minimum rate during transactions.
// [R9] Shutdown request bit set powers down all but the serial interface.
// [R10] Shutdown begins only after the running conversion finishes.
// [R11] With shutdown clear, conversions run back to back.
// [R12] The open-diode comparator is watched per conversion and sets the fault flag.
// [R13] Readers ignore a result whose fault flag is set.
// [R14] A shorted remote sensor reports the fixed short-circuit value.
// [R15] No conversion runs while the supply comparator says supply is low.
// [R16] Low supply sets the supply-invalid flag in both result registers.
// [R17] Comparator outputs pass a two-flop synchroniser before use.
// [R18] The timeout counts device clocks, cleared when both lines high or bus idle.
// [R19] Reads use the last written pointer, kept until the next write.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module temp_sensor_bus_status_ctrl #(
  parameter int unsigned TIMEOUT_CYCLES = tsm_pkg::TIMEOUT_CYC,
  parameter int unsigned CONV_CYCLES    = tsm_pkg::CONV_CYC,
  parameter logic [6:0]  DEV_ADDR       = tsm_pkg::DEV_ADDR_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        scl_clk,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             hs_filter_en,
  input  wire logic        open_cmp,
  input  wire logic        short_cmp,
  input  wire logic        supply_cmp,
  input  wire logic [11:0] adc_local,
  input  wire logic [11:0] adc_remote,
  output logic             analog_pd,
  output logic             adc_busy,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [15:0]      bus_rdata
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  link_if lk ();
  conv_if cv ();

  tsm_pkg::link_st_e st_q;
  tsm_pkg::link_st_e nxt_q;
  logic              scl_m1_q;
  logic              scl_m2_q;
  logic              scl_p_q;
  logic              sda_m1_q;
  logic              sda_m2_q;
  logic              sda_p_q;
  logic [3:0]        cnt_q;
  logic [7:0]        shreg_q;
  logic [7:0]        ptr_q;
  logic [7:0]        cfg_q;
  logic [15:0]       tx_q;
  logic              ack_q;
  logic              hs_mode_q;
  logic              open_q;
  logic [TW-1:0]     tmo_cnt_q;
  logic              start_ev;
  logic              stop_ev;
  logic              bit_ev;
  logic              scl_fall;
  logic              tmo_ev;
  logic              byte_end;
  logic [7:0]        byte_w;

  // Matches the high-speed master code in a received byte.
  function automatic logic is_hs(input logic [7:0] b);
    is_hs = (b & tsm_pkg::HS_MASK) == tsm_pkg::HS_CODE;
  endfunction : is_hs

  // Register selected by a pointer value; unknown pointers read as zero.
  function automatic logic [15:0] rd_sel(input logic [7:0]  p,
                                         input logic [15:0] lo,
                                         input logic [15:0] re,
                                         input logic [7:0]  cf);
    case (p)
      tsm_pkg::PTR_LOCAL:  rd_sel = lo;
      tsm_pkg::PTR_REMOTE: rd_sel = re;
      tsm_pkg::PTR_CFG1:   rd_sel = {cf, 8'h00};
      default:             rd_sel = 16'h0000;
    endcase
  endfunction : rd_sel

  link_sampler u_smp (
    .scl_clk (scl_clk),
    .sda_in  (sda_in),
    .lk      (lk.smp)
  );

  conv_ctrl #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_conv (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .cv         (cv.ctl),
    .open_cmp   (open_cmp),
    .short_cmp  (short_cmp),
    .supply_cmp (supply_cmp),
    .adc_local  (adc_local),
    .adc_remote (adc_remote),
    .analog_pd  (analog_pd),
    .adc_busy   (adc_busy)
  );

  // The shutdown bit of the first configuration register steers the sequencer.
  assign cv.sd_req = cfg_q[tsm_pkg::CFG_SD_BIT];                  // [R9]

  // Bus lines are sampled twice before use; a third flop gives the previous level.
  always_ff @(posedge mclk) begin
    scl_m1_q <= scl_in;
    scl_m2_q <= scl_m1_q;
    scl_p_q  <= scl_m2_q;
    sda_m1_q <= sda_in;
    sda_m2_q <= sda_m1_q;
    sda_p_q  <= sda_m2_q;
  end

  // Line events. The captured bit on the link clock is stable long before the rise is seen here.
  assign start_ev = scl_m2_q && scl_p_q && sda_p_q && !sda_m2_q;
  assign stop_ev  = scl_m2_q && scl_p_q && !sda_p_q && sda_m2_q;
  assign bit_ev   = scl_m2_q && !scl_p_q;
  assign scl_fall = !scl_m2_q && scl_p_q;
  assign byte_end = bit_ev && cnt_q == tsm_pkg::BIT_LAST;
  assign byte_w   = {shreg_q[6:0], lk.bit_val};

  // Transaction window between START and STOP; a timeout closes it as well.
  always_ff @(posedge mclk) begin
    if (!rst_n || stop_ev || tmo_ev) begin
      open_q <= 1'b0;
    end else if (start_ev) begin
      open_q <= 1'b1;
    end
  end

  // Bus-stuck counter. A master that clocks too slowly trips it by design.
  always_ff @(posedge mclk) begin
    if (!rst_n || !open_q || (scl_m2_q && sda_m2_q)) begin
      tmo_cnt_q <= '0;                                             // [R18]
    end else if (!tmo_ev) begin
      tmo_cnt_q <= tmo_cnt_q + TW'(1);                             // [R8] [R18]
    end
  end
  assign tmo_ev = open_q && (tmo_cnt_q == TW'(TIMEOUT_CYCLES - 1));  // [R6]

  // Slot state and bit counter. A timeout drops to idle, where only a START leads out.
  always_ff @(posedge mclk) begin
    if (!rst_n || tmo_ev) begin
      st_q  <= tsm_pkg::LK_IDLE;                                   // [R6] [R7]
      cnt_q <= 4'h0;
    end else if (start_ev) begin
      st_q  <= tsm_pkg::LK_ADDR;                                   // [R4]
      cnt_q <= 4'h0;
    end else if (stop_ev) begin
      st_q  <= tsm_pkg::LK_IDLE;
      cnt_q <= 4'h0;
    end else if (bit_ev && st_q != tsm_pkg::LK_IDLE) begin
      if (cnt_q != tsm_pkg::BIT_ACK) begin
        cnt_q <= cnt_q + 4'h1;
      end else begin
        cnt_q <= 4'h0;
        if (st_q == tsm_pkg::LK_RDATA && lk.bit_val) begin
          st_q <= tsm_pkg::LK_IGN;
        end else begin
          st_q <= nxt_q;
        end
      end
    end
  end

  // Byte decode: acknowledge and the state for the following byte slot.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shreg_q <= 8'h00;
      ack_q   <= 1'b0;
      nxt_q   <= tsm_pkg::LK_IGN;
    end else if (bit_ev && cnt_q != tsm_pkg::BIT_ACK) begin
      shreg_q <= byte_w;
      if (cnt_q == tsm_pkg::BIT_LAST) begin
        case (st_q)
          tsm_pkg::LK_ADDR: begin
            if (is_hs(byte_w)) begin
              ack_q <= 1'b0;                                       // [R1]
              nxt_q <= tsm_pkg::LK_HS;                             // [R3]
            end else if (byte_w[7:1] == DEV_ADDR) begin
              ack_q <= 1'b1;
              nxt_q <= byte_w[0] ? tsm_pkg::LK_RDATA : tsm_pkg::LK_PTR;
            end else begin
              ack_q <= 1'b0;
              nxt_q <= tsm_pkg::LK_IGN;
            end
          end
          tsm_pkg::LK_PTR, tsm_pkg::LK_WDATA: begin
            ack_q <= 1'b1;
            nxt_q <= tsm_pkg::LK_WDATA;
          end
          tsm_pkg::LK_RDATA: begin
            ack_q <= 1'b0;
            nxt_q <= tsm_pkg::LK_RDATA;
          end
          default: begin
            ack_q <= 1'b0;
            nxt_q <= tsm_pkg::LK_IGN;
          end
        endcase
      end
    end
  end

  // High-speed filters: entered on the master code, left on STOP or a timeout.
  always_ff @(posedge mclk) begin
    if (!rst_n || stop_ev || tmo_ev) begin
      hs_mode_q <= 1'b0;                                           // [R5]
    end else if (byte_end && st_q == tsm_pkg::LK_ADDR && is_hs(byte_w)) begin
      hs_mode_q <= 1'b1;                                           // [R2]
    end
  end
  assign hs_filter_en = hs_mode_q;

  // Pointer changes only on a pointer byte, so repeated reads reuse it.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ptr_q <= tsm_pkg::PTR_RST;
    end else if (byte_end && st_q == tsm_pkg::LK_PTR) begin
      ptr_q <= byte_w;                                             // [R19]
    end
  end

  // Configuration: a two-wire data byte aimed at it, or a plain-port write, which wins if both.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q <= tsm_pkg::CFG_RST;
    end else if (bus_wr && bus_addr == tsm_pkg::ADR_CFG) begin
      cfg_q <= bus_wdata[7:0];
    end else if (byte_end && st_q == tsm_pkg::LK_WDATA && ptr_q == tsm_pkg::PTR_CFG1) begin
      cfg_q <= byte_w;
    end
  end

  // Read shifter: loaded as the address is acknowledged, shifted MSB first.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_q <= 16'h0000;
    end else if (bit_ev && cnt_q == tsm_pkg::BIT_ACK && st_q == tsm_pkg::LK_ADDR
                 && nxt_q == tsm_pkg::LK_RDATA) begin
      tx_q <= rd_sel(ptr_q, cv.local_res, cv.remote_res, cfg_q);  // [R19]
    end else if (bit_ev && st_q == tsm_pkg::LK_RDATA && cnt_q != tsm_pkg::BIT_ACK) begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  // Open-drain data drive, changed only while the clock is low.
  // A START, a STOP or a timeout lets go at once so a stuck bus is freed.
  always_ff @(posedge mclk) begin
    if (!rst_n || tmo_ev || start_ev || stop_ev) begin
      sda_oe <= 1'b0;                                              // [R7]
    end else if (scl_fall) begin
      if (cnt_q == tsm_pkg::BIT_ACK) begin
        sda_oe <= ack_q;                                           // [R1]
      end else if (st_q == tsm_pkg::LK_RDATA) begin
        sda_oe <= !tx_q[15];
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end

  // The pin only ever pulls low.
  always_ff @(posedge mclk) begin
    sda_out <= 1'b0;
  end

  // Plain register port: data stands only in the cycle after the read strobe.
  always_ff @(posedge mclk) begin
    if (!rst_n || !bus_rd) begin
      bus_rdata <= 16'h0000;
    end else begin
      case (bus_addr)
        tsm_pkg::ADR_CFG:    bus_rdata <= {8'h00, cfg_q};
        tsm_pkg::ADR_STATUS: bus_rdata <= {11'h000, cv.powered_down, cv.converting, open_q, sda_oe, hs_mode_q};
        tsm_pkg::ADR_LOCAL:  bus_rdata <= cv.local_res;
        tsm_pkg::ADR_REMOTE: bus_rdata <= cv.remote_res;
        tsm_pkg::ADR_PTR:    bus_rdata <= {8'h00, ptr_q};
        tsm_pkg::ADR_SEL:    bus_rdata <= rd_sel(ptr_q, cv.local_res, cv.remote_res, cfg_q);
        default:             bus_rdata <= 16'h0000;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_hs_nack: assert property (byte_end && st_q == tsm_pkg::LK_ADDR && is_hs(byte_w)
                              |=> !ack_q && nxt_q == tsm_pkg::LK_HS)  // [R1]
    else $error("high-speed code acknowledged");
  a_hs_enter: assert property (byte_end && st_q == tsm_pkg::LK_ADDR && is_hs(byte_w)
                               |=> hs_mode_q ##1 hs_filter_en)  // [R2]
    else $error("high-speed filters not entered");
  a_hs_exit: assert property (stop_ev |=> !hs_filter_en)  // [R5]
    else $error("high-speed mode kept after stop");
  a_hs_hold: assert property (hs_mode_q && !stop_ev && !tmo_ev |=> hs_mode_q)  // [R5]
    else $error("high-speed mode lost before stop");
  a_tmo_fire: assert property (open_q && !(scl_m2_q && sda_m2_q) && tmo_cnt_q == TW'(TIMEOUT_CYCLES - 1)
                               |=> st_q == tsm_pkg::LK_IDLE && !open_q)  // [R6]
    else $error("timeout did not reset interface");
  a_tmo_release: assert property (tmo_ev |=> !sda_oe ##1 (st_q == tsm_pkg::LK_IDLE || $past(start_ev)))  // [R7]
    else $error("line held after timeout");
  a_tmo_clear: assert property ((scl_m2_q && sda_m2_q) || !open_q |=> tmo_cnt_q == '0)  // [R18]
    else $error("timeout counter not cleared");
  a_ptr_keep: assert property (!$stable(ptr_q) |-> $past(st_q) == tsm_pkg::LK_PTR && $past(byte_end))  // [R19]
    else $error("pointer changed outside pointer byte");

  c_hs_entry: cover property ($rose(hs_mode_q));
  c_timeout: cover property (tmo_ev);
  c_two_byte: cover property (bit_ev && st_q == tsm_pkg::LK_RDATA && cnt_q == tsm_pkg::BIT_ACK && !lk.bit_val);

endmodule : temp_sensor_bus_status_ctrl

`default_nettype wire

// ==== tw_master.sv ====
`timescale 1ns/100ps
`default_nettype none

// Two-wire master; lines rest high as if pulled up, and scl stands still between frames.
module tw_master (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // The odd lead-in keeps every later line edge off the rising mclk edges.
  task automatic start();
    #3;
    sda_m = 1'b1;
    #16;
    scl = 1'b1;
    #16;
    sda_m = 1'b0;
    #32;
    scl = 1'b0;
  endtask : start

  // One bit; data moves mid-low and scl never stalls inside a frame.
  task automatic bit_slot(input logic b, output logic r);
    #16;
    sda_m = b;
    #16;
    scl = 1'b1;
    #16;
    r = sda;
    #16;
    scl = 1'b0;
  endtask : bit_slot

  // Eight bits MSB first, then the acknowledge slot.
  task automatic xfer(input logic [7:0] b, input logic ma, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], r[i]);
    end
    bit_slot(ma, ak);
  endtask : xfer

  task automatic stop();
    #16;
    sda_m = 1'b0;
    #16;
    scl = 1'b1;
    #16;
    sda_m = 1'b1;
    #32;
  endtask : stop
endmodule : tw_master

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int TO = 200;
  localparam int CV = 20;
  localparam logic [7:0] AW = {tsm_pkg::DEV_ADDR_DEF, 1'b0};
  logic        mclk, rst_n, open_cmp, short_cmp, supply_cmp, bus_wr, bus_rd;
  logic        sda_out, sda_oe, hs, analog_pd, adc_busy, scl, sda_m, ack;
  logic [3:0]  bus_addr;
  logic [15:0] bus_wdata, bus_rdata, d;
  logic [7:0]  q;
  wire         sda;
  int          fails, n_compared, cyc;

  // The device only pulls low; otherwise the master level shows.
  assign sda = sda_oe ? sda_out : sda_m;

  tw_master m (.scl(scl), .sda_m(sda_m), .sda(sda));

  temp_sensor_bus_status_ctrl #(.TIMEOUT_CYCLES(TO), .CONV_CYCLES(CV)) dut (
    .mclk(mclk), .rst_n(rst_n), .scl_clk(scl), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .hs_filter_en(hs), .open_cmp(open_cmp), .short_cmp(short_cmp),
    .supply_cmp(supply_cmp), .adc_local(12'h123), .adc_remote(12'h456), .analog_pd(analog_pd),
    .adc_busy(adc_busy), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Register port; read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
    @(posedge mclk);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask : wr

  // Bounded wait, since a stuck flag must not hang the run.
  task automatic wt(ref logic s, input logic v);
    for (int i = 0; i < 60 && s !== v; i++) @(posedge mclk);
  endtask : wt

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    {rst_n, open_cmp, short_cmp, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    supply_cmp = 1'b1;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(tsm_pkg::ADR_CFG); chk(d, 16'h0000);
    rd(4'hf); chk(d, 16'h0000);
    wt(adc_busy, 1'b1); chk(16'(adc_busy), 16'h1);
    repeat (2 * CV) @(posedge mclk);
    rd(tsm_pkg::ADR_LOCAL); chk(d, 16'h1230);
    open_cmp <= 1'b1;
    repeat (3 * CV) @(posedge mclk);
    rd(tsm_pkg::ADR_REMOTE); chk(16'(d[0]), 16'h1);
    {open_cmp, short_cmp} <= 2'b01;
    repeat (3 * CV) @(posedge mclk);
    rd(tsm_pkg::ADR_REMOTE); chk(16'(d[15:8]), 16'h00c0);
    {short_cmp, supply_cmp} <= 2'b00;
    repeat (3 * CV) @(posedge mclk);
    chk(16'(adc_busy), 16'h0);
    rd(tsm_pkg::ADR_LOCAL); chk(16'(d[1]), 16'h1);
    rd(tsm_pkg::ADR_REMOTE); chk(16'(d[1]), 16'h1);
    supply_cmp <= 1'b1;
    wt(adc_busy, 1'b0);
    wt(adc_busy, 1'b1);
    wr(tsm_pkg::ADR_CFG, 16'h0040); chk(16'({analog_pd, adc_busy}), 16'h1);
    wt(analog_pd, 1'b1); chk(16'({analog_pd, adc_busy}), 16'h2);
    wr(tsm_pkg::ADR_CFG, 16'h0000);
    wt(adc_busy, 1'b1); chk(16'(adc_busy), 16'h1);
    m.start(); m.xfer(8'h09, 1'b1, q, ack); chk(16'(ack), 16'h1);
    #40 chk(16'(hs), 16'h1);
    @(posedge mclk);
    m.start(); m.xfer(AW, 1'b1, q, ack); chk(16'({hs, ack}), 16'h2);
    m.stop();
    #60 chk(16'(hs), 16'h0);
    @(posedge mclk);
    m.start(); m.xfer(AW, 1'b1, q, ack); m.xfer(8'h09, 1'b1, q, ack); m.xfer(8'h40, 1'b1, q, ack);
    m.stop();
    @(posedge mclk);
    rd(tsm_pkg::ADR_CFG); chk(d, 16'h0040);
    for (int k = 0; k < 2; k++) begin
      m.start(); m.xfer(AW | 8'h01, 1'b1, q, ack); m.xfer(8'hff, 1'b0, q, ack); chk(16'(q), 16'h0040);
      m.xfer(8'hff, 1'b1, q, ack); chk(16'(q), 16'h0000);
      m.stop();
      @(posedge mclk);
    end
    wr(tsm_pkg::ADR_CFG, 16'h0000);
    m.start();
    for (int i = 7; i >= 0; i--) m.bit_slot(AW[i], ack);
    #40 chk(16'(sda_oe), 16'h1);
    repeat (TO + 20) @(posedge mclk);
    chk(16'(sda_oe), 16'h0);
    rd(tsm_pkg::ADR_STATUS); chk(16'(d[2]), 16'h0);
    m.start(); m.xfer(AW, 1'b1, q, ack); chk(16'(ack), 16'h0);
    m.stop();
    test_done();
  end
endmodule : tb_top

`default_nettype wire
